/* File: logic/pcgl_counter.sv */
// periodic 32-bit counter with soft and hard gate, latch and retrigger
`timescale 1ns/1ps
module pcgl_counter (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // field signals
  input wire logic i_cnt_up,
  input wire logic i_cnt_dn,
  input wire logic i_aux_input,
  // isochronous instants
  input wire logic i_out_instant,
  input wire logic i_in_instant,
  // status
  output logic [31:0] o_count,
  output logic o_internal_gate_status,
  output logic o_input_level_status
);
  // address match shared by all write decodes
  function automatic logic pcgl_hit(input logic [7:0] a, input logic [7:0] off);
    pcgl_hit = (a == off);
  endfunction : pcgl_hit

  // one count step with the reload at the active limits
  function automatic logic [31:0] pcgl_step(input logic [31:0] c, input logic up,
      input pcgl_pkg::pcgl_dir_t d, input logic [31:0] hi, input logic [31:0] ld);
    logic [31:0] n;
    logic wrap;
    n = up ? c + pcgl_pkg::PCGL_ONE : c - pcgl_pkg::PCGL_ONE;
    case (d)
      pcgl_pkg::PCGL_DIR_UP: begin // settable upper limit
        wrap = up ? (n == hi || c == pcgl_pkg::PCGL_CNT_MAX) : (c == pcgl_pkg::PCGL_CNT_MIN);
      end
      pcgl_pkg::PCGL_DIR_DOWN: begin // lower limit fixed at zero
        wrap = up ? (c == pcgl_pkg::PCGL_CNT_MAX) : (n == pcgl_pkg::PCGL_ZERO);
      end
      default: begin // full signed range
        wrap = up ? (c == pcgl_pkg::PCGL_CNT_MAX) : (c == pcgl_pkg::PCGL_CNT_MIN);
      end
    endcase
    pcgl_step = wrap ? ld : n;
  endfunction : pcgl_step

  // software written state
  logic [8:0] cfg_q; // configuration word
  logic [31:0] upper_q; // high counting limit
  logic [31:0] load_q; // pending load value
  logic [31:0] cmp1_q; // compare value one
  logic [31:0] cmp2_q; // compare value two
  logic [31:0] ofu_q; // output function update word
  logic [15:0] filt_min_q; // filter minimum duration
  logic soft_bit_q; // soft gate bit as last written
  logic sync_en_q; // synchronisation enable bit
  // counting state
  logic [31:0] cnt_q; // live count
  logic [31:0] latch_q; // latch value
  logic soft_open_q; // soft gate open
  logic soft_pend_q; // soft opening waits for output instant
  logic hard_open_q; // hard gate open
  logic aux_q; // previous filtered aux level
  logic armed_q; // soft gate opened since configuration
  // feedback
  logic [31:0] fb_q; // feedback value
  logic [4:0] sts_q; // feedback status bits
  logic level_q; // aux level status
  logic [31:0] rdata_q; // read answer

  // decoded writes
  logic wr_ctrl, wr_cfg, wr_upper, wr_pload, wr_dload, wr_cmp1, wr_cmp2, wr_ofu, wr_filt;
  assign wr_ctrl = i_wr && pcgl_hit(i_addr, pcgl_pkg::PCGL_ADR_CTRL);
  assign wr_cfg = i_wr && pcgl_hit(i_addr, pcgl_pkg::PCGL_ADR_CFG);
  assign wr_upper = i_wr && pcgl_hit(i_addr, pcgl_pkg::PCGL_ADR_UPPER);
  assign wr_pload = i_wr && pcgl_hit(i_addr, pcgl_pkg::PCGL_ADR_PLOAD);
  assign wr_dload = i_wr && pcgl_hit(i_addr, pcgl_pkg::PCGL_ADR_DLOAD);
  assign wr_cmp1 = i_wr && pcgl_hit(i_addr, pcgl_pkg::PCGL_ADR_CMP1);
  assign wr_cmp2 = i_wr && pcgl_hit(i_addr, pcgl_pkg::PCGL_ADR_CMP2);
  assign wr_ofu = i_wr && pcgl_hit(i_addr, pcgl_pkg::PCGL_ADR_OFU);
  assign wr_filt = i_wr && pcgl_hit(i_addr, pcgl_pkg::PCGL_ADR_FILT);

  // configuration fields
  pcgl_pkg::pcgl_dir_t dir, new_dir;
  pcgl_pkg::pcgl_func_t func;
  logic cancel, iso, latching;
  logic [31:0] new_rst;
  assign dir = pcgl_pkg::pcgl_dir_t'(cfg_q[pcgl_pkg::PCGL_CFG_DIR_LSB +: 2]);
  assign new_dir = pcgl_pkg::pcgl_dir_t'(i_wdata[pcgl_pkg::PCGL_CFG_DIR_LSB +: 2]);
  assign func = pcgl_pkg::pcgl_func_t'(cfg_q[pcgl_pkg::PCGL_CFG_FUNC_LSB +: 3]);
  assign cancel = cfg_q[pcgl_pkg::PCGL_CFG_CANCEL];
  assign iso = cfg_q[pcgl_pkg::PCGL_CFG_ISO];
  assign latching = (func == pcgl_pkg::PCGL_FN_LATCH) || (func == pcgl_pkg::PCGL_FN_LATRIG);
  // reset state of load, count and latch for the direction being written
  assign new_rst = (new_dir == pcgl_pkg::PCGL_DIR_DOWN) ? upper_q : pcgl_pkg::PCGL_ZERO;

  // aux input filter
  pcgl_filt_if filt_bus ();
  assign filt_bus.raw = i_aux_input;
  assign filt_bus.en = cfg_q[pcgl_pkg::PCGL_CFG_FILTER];
  assign filt_bus.min_cyc = filt_min_q;
  pcgl_filter u_filter (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .f(filt_bus.usr)
  );

  // gate and edge events
  logic filt, hlevel, aux_rise, hard_rise, sg_rise, sg_fall, soft_set, soft_opening;
  logic gate, open_reload, capture, retrig, sync_ld, step_en;
  assign filt = filt_bus.filt;
  assign hlevel = filt ^ cfg_q[pcgl_pkg::PCGL_CFG_INVERT];
  assign aux_rise = filt && !aux_q;
  assign hard_rise = (func == pcgl_pkg::PCGL_FN_HGATE) && hlevel && !hard_open_q;
  assign sg_rise = wr_ctrl && i_wdata[pcgl_pkg::PCGL_CTRL_SOFT] && !soft_bit_q;
  assign sg_fall = wr_ctrl && !i_wdata[pcgl_pkg::PCGL_CTRL_SOFT];
  // isochronous opening waits for the output instant
  assign soft_set = iso ? (soft_pend_q && i_out_instant && soft_bit_q) : sg_rise;
  assign soft_opening = soft_set && !soft_open_q;
  // internal gate: soft alone, or soft AND hard
  assign gate = soft_open_q && ((func != pcgl_pkg::PCGL_FN_HGATE) || hard_open_q);
  // reload on opening: cancel mode outside retrigger, or first latch opening, never when soft opens behind an open hard gate
  always_comb begin
    open_reload = 1'b0;
    case (func)
      pcgl_pkg::PCGL_FN_HGATE: open_reload = cancel && hard_rise && soft_open_q;
      pcgl_pkg::PCGL_FN_LATRIG: open_reload = 1'b0; // only pauses
      pcgl_pkg::PCGL_FN_LATCH: open_reload = soft_opening && (cancel || !armed_q);
      default: open_reload = soft_opening && cancel;
    endcase
  end
  // captures run after the first soft opening, even with the gate closed
  assign capture = armed_q && aux_rise && latching;
  assign retrig = capture && (func == pcgl_pkg::PCGL_FN_LATRIG);
  assign sync_ld = (func == pcgl_pkg::PCGL_FN_SYNC) && aux_rise && soft_open_q && sync_en_q;
  assign step_en = gate && (i_cnt_up ^ i_cnt_dn);

  // control bits and soft gate
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin // gates closed at reset
      soft_bit_q <= 1'b0;
      sync_en_q <= 1'b0;
      soft_open_q <= 1'b0;
      soft_pend_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        soft_bit_q <= i_wdata[pcgl_pkg::PCGL_CTRL_SOFT];
        sync_en_q <= i_wdata[pcgl_pkg::PCGL_CTRL_SYNC];
      end
      if (sg_fall) begin // clearing the bit closes at once
        soft_open_q <= 1'b0;
        soft_pend_q <= 1'b0;
      end else if (soft_set) begin // opening
        soft_open_q <= 1'b1;
        soft_pend_q <= 1'b0;
      end else if (sg_rise) begin // isochronous: hold until output instant
        soft_pend_q <= 1'b1;
      end
    end
  end

  // hard gate and aux level tracking
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      hard_open_q <= 1'b0;
      aux_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      hard_open_q <= (func == pcgl_pkg::PCGL_FN_HGATE) && hlevel;
      aux_q <= filt;
      level_q <= filt;
    end
  end

  // configuration and limit registers
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_q <= pcgl_pkg::PCGL_CFG_RST;
      upper_q <= pcgl_pkg::PCGL_UPPER_RST;
      filt_min_q <= pcgl_pkg::PCGL_FILT_RST;
      ofu_q <= pcgl_pkg::PCGL_ZERO;
    end else begin
      if (wr_cfg) cfg_q <= i_wdata[pcgl_pkg::PCGL_CFG_W-1:0];
      if (wr_upper) upper_q <= i_wdata;
      if (wr_filt) filt_min_q <= i_wdata[15:0];
      if (wr_ofu) ofu_q <= i_wdata;
    end
  end

  // load and compare values
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      load_q <= pcgl_pkg::PCGL_ZERO;
      cmp1_q <= pcgl_pkg::PCGL_ZERO;
      cmp2_q <= pcgl_pkg::PCGL_ZERO;
    end else if (wr_cfg) begin
      load_q <= new_rst;
      cmp1_q <= new_rst;
      cmp2_q <= new_rst;
    end else begin
      if (wr_pload) load_q <= i_wdata;
      if (wr_cmp1) cmp1_q <= i_wdata;
      if (wr_cmp2) cmp2_q <= i_wdata;
    end
  end

  // live count: configuration, direct load, reload, then counting
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= pcgl_pkg::PCGL_ZERO;
    end else if (wr_cfg) begin
      cnt_q <= new_rst;
    end else if (wr_dload) begin
      cnt_q <= i_wdata;
    end else if (retrig || sync_ld || open_reload) begin
      cnt_q <= load_q;
    end else if (step_en) begin
      cnt_q <= pcgl_step(cnt_q, i_cnt_up, dir, upper_q, load_q);
    end
  end

  // latch value and arming; the latch is untouched by direct load and soft opening
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      latch_q <= pcgl_pkg::PCGL_ZERO;
      armed_q <= 1'b0;
    end else if (wr_cfg) begin
      latch_q <= new_rst;
      armed_q <= 1'b0;
    end else begin
      if (capture) latch_q <= cnt_q;
      if (soft_opening) armed_q <= 1'b1;
    end
  end

  // feedback sampled every clock, or at the input instant when isochronous
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      fb_q <= pcgl_pkg::PCGL_ZERO;
      sts_q <= '0;
    end else if (!iso || i_in_instant) begin
      fb_q <= latching ? latch_q : cnt_q;
      sts_q[pcgl_pkg::PCGL_INTERNAL_GATE_STATUS] <= gate;
      sts_q[pcgl_pkg::PCGL_STS_LEVEL] <= level_q;
      sts_q[pcgl_pkg::PCGL_STS_SOFT] <= soft_open_q;
      sts_q[pcgl_pkg::PCGL_STS_HARD] <= hard_open_q;
      sts_q[pcgl_pkg::PCGL_STS_ARMED] <= armed_q;
    end
  end

  // read answer, one cycle after the strobe and zero otherwise
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= pcgl_pkg::PCGL_ZERO;
    end else if (!i_rd) begin
      rdata_q <= pcgl_pkg::PCGL_ZERO;
    end else begin
      case (i_addr)
        pcgl_pkg::PCGL_ADR_CTRL: rdata_q <= {30'h0, sync_en_q, soft_bit_q};
        pcgl_pkg::PCGL_ADR_CFG: rdata_q <= {23'h0, cfg_q};
        pcgl_pkg::PCGL_ADR_UPPER: rdata_q <= upper_q;
        pcgl_pkg::PCGL_ADR_PLOAD: rdata_q <= load_q;
        pcgl_pkg::PCGL_ADR_CMP1: rdata_q <= cmp1_q;
        pcgl_pkg::PCGL_ADR_CMP2: rdata_q <= cmp2_q;
        pcgl_pkg::PCGL_ADR_OFU: rdata_q <= ofu_q;
        pcgl_pkg::PCGL_ADR_FILT: rdata_q <= {16'h0, filt_min_q};
        pcgl_pkg::PCGL_ADR_STATUS: rdata_q <= {27'h0, sts_q};
        pcgl_pkg::PCGL_ADR_FBACK: rdata_q <= fb_q;
        pcgl_pkg::PCGL_ADR_LIVE: rdata_q <= cnt_q;
        default: rdata_q <= pcgl_pkg::PCGL_ZERO; // unmapped and write-only
      endcase
    end
  end

  // outputs
  assign o_rdata = rdata_q;
  assign o_count = cnt_q;
  assign o_internal_gate_status = gate;
  assign o_input_level_status = level_q;

  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  logic quiet; // nothing but counting can move the count
  assign quiet = !wr_cfg && !wr_dload && !retrig && !sync_ld && !open_reload;

  gate_hold_a: assert property (quiet && !gate |=> cnt_q == $past(cnt_q))
    else $error("count moved with the gate closed");
  step_up_a: assert property (quiet && gate && i_cnt_up && !i_cnt_dn
      && cnt_q != pcgl_pkg::PCGL_CNT_MAX && cnt_q + pcgl_pkg::PCGL_ONE != upper_q
      |=> cnt_q == $past(cnt_q) + pcgl_pkg::PCGL_ONE)
    else $error("up pulse did not add one");
  wrap_full_a: assert property (quiet && gate && dir == pcgl_pkg::PCGL_DIR_NONE
      && !i_cnt_up && i_cnt_dn && cnt_q == pcgl_pkg::PCGL_CNT_MIN
      |=> cnt_q == $past(load_q))
    else $error("underflow did not reload");
  wrap_upper_a: assert property (quiet && gate && dir == pcgl_pkg::PCGL_DIR_UP
      && i_cnt_up && !i_cnt_dn && cnt_q + pcgl_pkg::PCGL_ONE == upper_q
      |=> cnt_q == $past(load_q))
    else $error("upper limit did not reload");
  wrap_zero_a: assert property (quiet && gate && dir == pcgl_pkg::PCGL_DIR_DOWN
      && i_cnt_dn && !i_cnt_up && cnt_q == pcgl_pkg::PCGL_ONE
      |=> cnt_q == $past(load_q))
    else $error("zero limit did not reload");
  retrig_a: assert property (retrig && !wr_cfg && !wr_dload
      |=> latch_q == $past(cnt_q) && cnt_q == $past(load_q))
    else $error("retrigger did not latch and reload");
  latch_keep_a: assert property (wr_dload && !wr_cfg && !capture
      |=> latch_q == $past(latch_q) ##1 ($past(iso) || !$past(latching)
      || fb_q == $past(latch_q, 2)))
    else $error("direct load disturbed the latch value");
  soft_edge_a: assert property (!iso && $rose(soft_open_q) |-> $past(sg_rise))
    else $error("soft gate opened without a rising bit");
  iso_start_a: assert property (iso && soft_pend_q && i_out_instant
      && soft_bit_q && !sg_fall |=> soft_open_q)
    else $error("isochronous opening missed the output instant");
  level_a: assert property (##1 o_input_level_status == $past(filt))
    else $error("level status does not follow the input");
  cfg_rst_a: assert property (wr_cfg && new_dir == pcgl_pkg::PCGL_DIR_DOWN
      |=> cnt_q == $past(upper_q) && load_q == $past(upper_q))
    else $error("configuration reset state wrong");
  resume_a: assert property (func == pcgl_pkg::PCGL_FN_HGATE && hard_open_q
      && soft_opening && !wr_cfg && !wr_dload |=> cnt_q == $past(cnt_q))
    else $error("soft opening behind open hard gate reloaded");
  // isochronous, latch and hard gate checks
  iso_wait_a: assert property (iso && !soft_open_q && !(soft_pend_q && i_out_instant)
      |=> !soft_open_q)
    else $error("isochronous soft gate opened off the output instant");
  fb_hold_a: assert property (iso && !i_in_instant |=> fb_q == $past(fb_q))
    else $error("isochronous feedback moved between input instants");
  latch_exact_a: assert property (capture && !wr_cfg |=> latch_q == $past(cnt_q))
    else $error("latch value is not the count at the edge");
  hard_gate_a: assert property (func == pcgl_pkg::PCGL_FN_HGATE
      |=> hard_open_q == $past(hlevel))
    else $error("hard gate does not follow the aux level");

  wrap_c: cover property (wr_cfg ##[1:20] step_en && cnt_q + pcgl_pkg::PCGL_ONE == upper_q);
  retrig_c: cover property (retrig ##[1:50] retrig);
  hard_c: cover property (hard_rise && soft_open_q);
  iso_c: cover property (iso && soft_opening);
  latch_c: cover property (capture && !gate);
endmodule : pcgl_counter

/* File: pkg/pcgl_pkg.sv */
// constants, field layout and enumerations of the periodic counter with gate and latch
package pcgl_pkg;
  // register byte addresses
  localparam logic [7:0] PCGL_ADR_CTRL = 8'h00;
  localparam logic [7:0] PCGL_ADR_CFG = 8'h04;
  localparam logic [7:0] PCGL_ADR_UPPER = 8'h08;
  localparam logic [7:0] PCGL_ADR_PLOAD = 8'h0c;
  localparam logic [7:0] PCGL_ADR_DLOAD = 8'h10;
  localparam logic [7:0] PCGL_ADR_CMP1 = 8'h14;
  localparam logic [7:0] PCGL_ADR_CMP2 = 8'h18;
  localparam logic [7:0] PCGL_ADR_OFU = 8'h1c;
  localparam logic [7:0] PCGL_ADR_FILT = 8'h20;
  localparam logic [7:0] PCGL_ADR_STATUS = 8'h24;
  localparam logic [7:0] PCGL_ADR_FBACK = 8'h28;
  localparam logic [7:0] PCGL_ADR_LIVE = 8'h2c;
  // control word bits
  localparam int PCGL_CTRL_SOFT = 0;
  localparam int PCGL_CTRL_SYNC = 1;
  // configuration word fields
  localparam int PCGL_CFG_DIR_LSB = 0;
  localparam int PCGL_CFG_FUNC_LSB = 2;
  localparam int PCGL_CFG_CANCEL = 5;
  localparam int PCGL_CFG_INVERT = 6;
  localparam int PCGL_CFG_FILTER = 7;
  localparam int PCGL_CFG_ISO = 8;
  localparam int PCGL_CFG_W = 9;
  localparam logic [8:0] PCGL_CFG_RST = 9'h000;
  // status word bits
  localparam int PCGL_INTERNAL_GATE_STATUS = 0;
  localparam int PCGL_STS_LEVEL = 1;
  localparam int PCGL_STS_SOFT = 2;
  localparam int PCGL_STS_HARD = 3;
  localparam int PCGL_STS_ARMED = 4;
  localparam int PCGL_STS_W = 5;
  // count range and reset values
  localparam logic [31:0] PCGL_CNT_MAX = 32'h7fffffff;
  localparam logic [31:0] PCGL_CNT_MIN = 32'h80000000;
  localparam logic [31:0] PCGL_ZERO = 32'h00000000;
  localparam logic [31:0] PCGL_ONE = 32'h00000001;
  localparam logic [31:0] PCGL_UPPER_RST = 32'h7fffffff;
  localparam logic [15:0] PCGL_FILT_RST = 16'h0004;
  localparam logic [15:0] PCGL_FILT_ONE = 16'h0001;
  // main count direction
  typedef enum logic [1:0] {PCGL_DIR_NONE, PCGL_DIR_UP, PCGL_DIR_DOWN} pcgl_dir_t;
  // aux input function
  typedef enum logic [2:0] {
    PCGL_FN_INPUT, PCGL_FN_HGATE, PCGL_FN_LATCH, PCGL_FN_LATRIG, PCGL_FN_SYNC
  } pcgl_func_t;
endpackage : pcgl_pkg

/* File: pkg/pcgl_filt_if.sv */
// aux input filter connection between counter core and filter
`timescale 1ns/1ps
interface pcgl_filt_if;
  logic raw; // unfiltered aux input
  logic en; // filter switched on
  logic [15:0] min_cyc; // least stable time in clocks
  logic filt; // filtered level
  modport flt (input raw, input en, input min_cyc, output filt);
  modport usr (output raw, output en, output min_cyc, input filt);
endinterface : pcgl_filt_if

/* File: logic/pcgl_filter.sv */
// minimum pulse duration filter for the aux input
`timescale 1ns/1ps
module pcgl_filter (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // filter connection
  pcgl_filt_if.flt f
);
  logic filt_q; // accepted level
  logic [15:0] run_q; // cycles the new level has stood

  // with the filter on, a level is accepted only after standing min_cyc clocks
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      filt_q <= 1'b0;
      run_q <= 16'h0000;
    end else if (!f.en) begin // bypass
      filt_q <= f.raw;
      run_q <= 16'h0000;
    end else if (f.raw == filt_q) begin // glitch ended, start over
      run_q <= 16'h0000;
    end else if (run_q + pcgl_pkg::PCGL_FILT_ONE >= f.min_cyc) begin
      filt_q <= f.raw; // stood long enough
      run_q <= 16'h0000;
    end else begin
      run_q <= run_q + pcgl_pkg::PCGL_FILT_ONE;
    end
  end

  assign f.filt = filt_q;

  filt_min_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    f.en && $changed(filt_q) |-> $past(f.raw) == filt_q)
    else $error("filter passed a level that was not present");
endmodule : pcgl_filter

/* File: verif/pcgl_field_model.sv */
// field side model: count pulses and aux input level
`timescale 1ns/1ps
module pcgl_field_model (
  // clock
  input wire logic i_mclk,
  // field signals
  output logic o_cnt_up,
  output logic o_cnt_dn,
  output logic o_aux_input
);
  // idle levels from time zero
  initial begin
    o_cnt_up = 1'b0;
    o_cnt_dn = 1'b0;
    o_aux_input = 1'b0;
  end
  // n one-cycle pulses, never both directions at once
  task automatic pulses(input int n, input bit up);
    repeat (n) begin
      @(posedge i_mclk);
      o_cnt_up <= up;
      o_cnt_dn <= !up;
      @(posedge i_mclk);
      o_cnt_up <= 1'b0;
      o_cnt_dn <= 1'b0;
    end
  endtask : pulses
  // new aux level, then time for edge detect and capture
  task automatic aux(input bit lvl);
    @(posedge i_mclk);
    o_aux_input <= lvl;
    repeat (6) @(posedge i_mclk);
  endtask : aux
  // aux pulse of n clocks, then time for the filter to settle
  task automatic glitch(input int n);
    @(posedge i_mclk);
    o_aux_input <= 1'b1;
    repeat (n) @(posedge i_mclk);
    o_aux_input <= 1'b0;
    repeat (6) @(posedge i_mclk);
  endtask : glitch
endmodule : pcgl_field_model

/* File: verif/tb_top.sv */
// self-checking bench for the periodic counter with gate and latch
`timescale 1ns/1ps
module tb_top;
  logic mclk; // system clock
  logic nrst; // reset, active low
  logic [7:0] addr; // register bus
  logic [31:0] wdata;
  logic wr_s;
  logic rd_s;
  logic [31:0] rdata;
  logic [31:0] count; // live count port
  logic gate; // internal gate port
  logic level; // aux level port
  logic up, dn, aux; // field lines from the model
  logic oi; // isochronous output instant
  logic ii; // isochronous input instant
  int bad_count = 0;
  int samples_checked = 0;
  // 200 MHz clock
  always #2.5 mclk = ~mclk;
  pcgl_counter dut (.i_mclk(mclk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_cnt_up(up), .i_cnt_dn(dn),
    .i_aux_input(aux), .i_out_instant(oi), .i_in_instant(ii), .o_count(count),
    .o_internal_gate_status(gate), .o_input_level_status(level));
  pcgl_field_model fm (.i_mclk(mclk), .o_cnt_up(up), .o_cnt_dn(dn), .o_aux_input(aux));
  // compare and count
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // one-cycle write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
  endtask : wr
  // one-cycle read, data checked in the following cycle
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    #1;
    cmp(rdata, e);
  endtask : chk
  // one-cycle isochronous instant, output or input
  task automatic instant(input bit out_sel);
    @(posedge mclk);
    if (out_sel) oi <= 1'b1;
    else ii <= 1'b1;
    @(posedge mclk);
    oi <= 1'b0;
    ii <= 1'b0;
  endtask : instant
  // counts and verdict
  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // hang guard
  initial begin
    #400000;
    bad_count++;
    $display("mismatch at %0t: run timed out", $time);
    complete_run();
  end
  // main sequence
  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    oi = 1'b0;
    ii = 1'b0;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    chk(pcgl_pkg::PCGL_ADR_CFG, 32'h0);
    chk(pcgl_pkg::PCGL_ADR_UPPER, 32'h7fffffff);
    chk(pcgl_pkg::PCGL_ADR_FILT, 32'h4);
    chk(pcgl_pkg::PCGL_ADR_LIVE, 32'h0);
    chk(8'h30, 32'h0);
    chk(pcgl_pkg::PCGL_ADR_DLOAD, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(pcgl_pkg::PCGL_ADR_CFG, 32'(i) << 2);
      chk(pcgl_pkg::PCGL_ADR_CFG, 32'(i) << 2);
    end
    $display("test reset and config done");
    wr(pcgl_pkg::PCGL_ADR_CFG, 32'h0);
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h1);
    #1 cmp(gate, 1'b1);
    fm.pulses(3, 1'b1);
    chk(pcgl_pkg::PCGL_ADR_LIVE, 32'h3);
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h0);
    fm.pulses(2, 1'b1);
    chk(pcgl_pkg::PCGL_ADR_LIVE, 32'h3);
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h1);
    fm.pulses(1, 1'b0);
    chk(pcgl_pkg::PCGL_ADR_LIVE, 32'h2);
    wr(pcgl_pkg::PCGL_ADR_CMP1, 32'h11);
    wr(pcgl_pkg::PCGL_ADR_CMP2, 32'h22);
    wr(pcgl_pkg::PCGL_ADR_OFU, 32'h3);
    chk(pcgl_pkg::PCGL_ADR_CMP1, 32'h11);
    chk(pcgl_pkg::PCGL_ADR_CMP2, 32'h22);
    chk(pcgl_pkg::PCGL_ADR_OFU, 32'h3);
    $display("test gate done");
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h0);
    wr(pcgl_pkg::PCGL_ADR_UPPER, 32'h5);
    wr(pcgl_pkg::PCGL_ADR_CFG, 32'h1);
    wr(pcgl_pkg::PCGL_ADR_PLOAD, 32'h2);
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h1);
    fm.pulses(5, 1'b1);
    chk(pcgl_pkg::PCGL_ADR_LIVE, 32'h2);
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h0);
    wr(pcgl_pkg::PCGL_ADR_CFG, 32'h2);
    chk(pcgl_pkg::PCGL_ADR_LIVE, 32'h5);
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h1);
    fm.pulses(4, 1'b0);
    chk(pcgl_pkg::PCGL_ADR_LIVE, 32'h1);
    fm.pulses(1, 1'b0);
    chk(pcgl_pkg::PCGL_ADR_LIVE, 32'h5);
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h0);
    wr(pcgl_pkg::PCGL_ADR_CFG, 32'h0);
    wr(pcgl_pkg::PCGL_ADR_PLOAD, 32'h9);
    wr(pcgl_pkg::PCGL_ADR_DLOAD, 32'h7fffffff);
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h1);
    fm.pulses(1, 1'b1);
    chk(pcgl_pkg::PCGL_ADR_LIVE, 32'h9);
    $display("test directions done");
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h0);
    wr(pcgl_pkg::PCGL_ADR_CFG, 32'h28);
    wr(pcgl_pkg::PCGL_ADR_PLOAD, 32'ha);
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h1);
    chk(pcgl_pkg::PCGL_ADR_LIVE, 32'ha);
    fm.pulses(3, 1'b1);
    fm.aux(1'b1);
    chk(pcgl_pkg::PCGL_ADR_FBACK, 32'hd);
    cmp(level, 1'b1);
    wr(pcgl_pkg::PCGL_ADR_DLOAD, 32'h64);
    chk(pcgl_pkg::PCGL_ADR_FBACK, 32'hd);
    chk(pcgl_pkg::PCGL_ADR_LIVE, 32'h64);
    fm.aux(1'b0);
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h0);
    fm.aux(1'b1);
    chk(pcgl_pkg::PCGL_ADR_FBACK, 32'h64);
    fm.aux(1'b0);
    wr(pcgl_pkg::PCGL_ADR_CFG, 32'hc);
    wr(pcgl_pkg::PCGL_ADR_PLOAD, 32'h4);
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h1);
    fm.pulses(3, 1'b1);
    fm.aux(1'b1);
    chk(pcgl_pkg::PCGL_ADR_FBACK, 32'h3);
    chk(pcgl_pkg::PCGL_ADR_LIVE, 32'h4);
    fm.aux(1'b0);
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h0);
    fm.pulses(2, 1'b1);
    chk(pcgl_pkg::PCGL_ADR_LIVE, 32'h4);
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h1);
    fm.pulses(1, 1'b1);
    chk(pcgl_pkg::PCGL_ADR_LIVE, 32'h5);
    $display("test latch done");
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h0);
    wr(pcgl_pkg::PCGL_ADR_CFG, 32'h4);
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h1);
    #1 cmp(gate, 1'b0);
    fm.pulses(2, 1'b1);
    chk(pcgl_pkg::PCGL_ADR_LIVE, 32'h0);
    fm.aux(1'b1);
    #1 cmp(gate, 1'b1);
    fm.pulses(2, 1'b1);
    chk(pcgl_pkg::PCGL_ADR_LIVE, 32'h2);
    fm.aux(1'b0);
    #1 cmp(gate, 1'b0);
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h0);
    wr(pcgl_pkg::PCGL_ADR_CFG, 32'h24);
    wr(pcgl_pkg::PCGL_ADR_PLOAD, 32'h7);
    fm.aux(1'b1);
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h1);
    fm.pulses(2, 1'b1);
    chk(pcgl_pkg::PCGL_ADR_LIVE, 32'h2);
    fm.aux(1'b0);
    fm.aux(1'b1);
    fm.pulses(1, 1'b1);
    #1 cmp(count, 32'h8);
    fm.aux(1'b0);
    $display("test hard gate done");
    wr(pcgl_pkg::PCGL_ADR_CFG, 32'h80);
    fm.glitch(2);
    cmp(level, 1'b0);
    fm.aux(1'b1);
    cmp(level, 1'b1);
    fm.aux(1'b0);
    $display("test filter done");
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h0);
    wr(pcgl_pkg::PCGL_ADR_CFG, 32'h100);
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h1);
    #1 cmp(gate, 1'b0);
    fm.pulses(2, 1'b1);
    instant(1'b1);
    #1 cmp(gate, 1'b1);
    fm.pulses(3, 1'b1);
    instant(1'b0);
    fm.pulses(2, 1'b1);
    chk(pcgl_pkg::PCGL_ADR_FBACK, 32'h3);
    chk(pcgl_pkg::PCGL_ADR_LIVE, 32'h5);
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h0);
    wr(pcgl_pkg::PCGL_ADR_CFG, 32'h104);
    wr(pcgl_pkg::PCGL_ADR_CTRL, 32'h1);
    instant(1'b1);
    fm.pulses(1, 1'b1);
    #1 cmp(gate, 1'b0);
    fm.aux(1'b1);
    #1 cmp(gate, 1'b1);
    fm.pulses(1, 1'b1);
    #1 cmp(count, 32'h1);
    $display("test isochronous done");
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    #1 cmp(count, 32'h0);
    cmp(gate, 1'b0);
    chk(pcgl_pkg::PCGL_ADR_CTRL, 32'h0);
    $display("test reset done");
    complete_run();
  end
endmodule : tb_top
